// ==== verilog/exec_pkg.sv ====
package exec_pkg;
  localparam int REG_COUNT = 32;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 5;
  localparam int OFFS_W = 6;
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // low register of each pointer pair
  localparam logic [IDX_W-1:0] PTR_X_LO = 5'h1A;
  localparam logic [IDX_W-1:0] PTR_Y_LO = 5'h1C;
  localparam logic [IDX_W-1:0] PTR_Z_LO = 5'h1E;
  localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ptr_sel_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_BIT_TO_TRANSFER_COPY = 4'h1,
    OP_TRANSFER_TO_BIT_WRITE = 4'h2,
    OP_FLAG_SET = 4'h3,
    OP_FLAG_CLEAR = 4'h4,
    OP_REGISTER_MOVE = 4'h5,
    OP_REGISTER_PAIR_COPY = 4'h6,
    OP_IMMEDIATE_LOAD = 4'h7,
    OP_INDIRECT_LOAD = 4'h8,
    OP_INDIRECT_LOAD_POST_INC = 4'h9,
    OP_INDIRECT_LOAD_PRE_DEC = 4'hA,
    OP_OFFSET_INDIRECT_LOAD = 4'hB
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01
  } state_t;
endpackage

// ==== verilog/flag_bit_and_indirect_load_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module flag_bit_and_indirect_load_exec #(
  parameter int NUM_REGS = exec_pkg::REG_COUNT // working registers
) (
  input wire logic clk_sys_i, // core clock, 200 MHz
  input wire logic reset_n_i, // async reset, active low
  input wire logic issue_i, // instruction valid, taken when not busy
  input wire exec_pkg::op_t op_i, // decoded operation
  input wire logic [exec_pkg::IDX_W-1:0] rd_idx_i, // destination register
  input wire logic [exec_pkg::IDX_W-1:0] rr_idx_i, // source register
  input wire logic [2:0] bit_sel_i, // bit number or flag number
  input wire logic [exec_pkg::DATA_W-1:0] imm_i, // immediate byte
  input wire exec_pkg::ptr_sel_t ptr_sel_i, // pointer pair select
  input wire logic [exec_pkg::OFFS_W-1:0] offset_i, // unsigned displacement
  input wire logic [exec_pkg::DATA_W-1:0] mem_data_i, // data memory read data
  input wire logic [exec_pkg::IDX_W-1:0] rf_rd_idx_i, // register peek index
  output logic busy_o, // load in progress
  output logic done_o, // one-cycle pulse per finished instruction
  output logic mem_rd_o, // data memory read strobe
  output logic [exec_pkg::ADDR_W-1:0] mem_addr_o, // data memory address
  output logic [exec_pkg::DATA_W-1:0] status_flags_o, // status flags
  output logic [exec_pkg::DATA_W-1:0] rf_rd_data_o // register peek data
);
  import exec_pkg::*;

  // five-bit indices and the pointer pairs need exactly a full file
  if (NUM_REGS != 2 ** IDX_W) begin : g_check_regs
    $error("register file size must match the index width");
  end
  if (ADDR_W != 2 * DATA_W) begin : g_check_ptr
    $error("a pointer pair must span two register bytes");
  end

  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [DATA_W-1:0] next_regs [NUM_REGS];
  logic [DATA_W-1:0] flags, next_flags;
  state_t state, next_state;
  op_t ld_op, next_ld_op;
  logic [IDX_W-1:0] ld_rd, next_ld_rd;
  logic [IDX_W-1:0] ld_ptr_lo, next_ld_ptr_lo;
  logic busy, next_busy;
  logic done, next_done;
  logic mem_rd, next_mem_rd;
  logic [ADDR_W-1:0] mem_addr, next_mem_addr;
  logic [DATA_W-1:0] rf_rd_data, next_rf_rd_data;

  function automatic logic [IDX_W-1:0] ptr_lo(input ptr_sel_t sel);
    logic [IDX_W-1:0] lo;
    lo = PTR_Z_LO;
    case (sel)
      PTR_X: lo = PTR_X_LO;
      PTR_Y: lo = PTR_Y_LO;
      default: lo = PTR_Z_LO;
    endcase
    return lo;
  endfunction

  function automatic logic [IDX_W-1:0] hi_of(input logic [IDX_W-1:0] lo);
    return {lo[IDX_W-1:1], 1'b1};
  endfunction

  always_comb begin
    logic [IDX_W-1:0] lo;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] step_addr;
    lo = ptr_lo(ptr_sel_i);
    ptr = {regs[hi_of(lo)], regs[lo]};
    step_addr = mem_addr + PTR_STEP;
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_state = state;
    next_ld_op = ld_op;
    next_ld_rd = ld_rd;
    next_ld_ptr_lo = ld_ptr_lo;
    next_busy = busy;
    next_done = 1'b0;
    next_mem_rd = 1'b0;
    next_mem_addr = mem_addr;
    case (state)
      ST_IDLE: begin
        if (issue_i) begin
          next_done = 1'b1;
          case (op_i)
            OP_TRANSFER_TO_BIT_WRITE: begin
              next_regs[rd_idx_i][bit_sel_i] = flags[FLAG_T];
            end
            OP_REGISTER_MOVE: begin
              next_regs[rd_idx_i] = regs[rr_idx_i];
            end
            OP_REGISTER_PAIR_COPY: begin
              // pair indices use only the upper four bits
              next_regs[{rd_idx_i[IDX_W-1:1], 1'b0}] =
                regs[{rr_idx_i[IDX_W-1:1], 1'b0}];
              next_regs[{rd_idx_i[IDX_W-1:1], 1'b1}] =
                regs[{rr_idx_i[IDX_W-1:1], 1'b1}];
            end
            OP_IMMEDIATE_LOAD: begin
              next_regs[rd_idx_i] = imm_i;
            end
            OP_INDIRECT_LOAD, OP_INDIRECT_LOAD_POST_INC,
            OP_INDIRECT_LOAD_PRE_DEC, OP_OFFSET_INDIRECT_LOAD: begin
              next_done = 1'b0;
              next_state = ST_LOAD;
              next_busy = 1'b1;
              next_mem_rd = 1'b1;
              next_ld_op = op_i;
              next_ld_rd = rd_idx_i;
              next_ld_ptr_lo = lo;
              next_mem_addr = ptr;
              if (op_i == OP_INDIRECT_LOAD_PRE_DEC) begin
                next_mem_addr = ptr - PTR_STEP;
              end else if (op_i == OP_OFFSET_INDIRECT_LOAD) begin
                next_mem_addr = ptr + {{(ADDR_W-OFFS_W){1'b0}},
                  offset_i};
              end
            end
            default: begin
              next_done = 1'b1;
            end
          endcase
        end
      end
      ST_LOAD: begin
        next_regs[ld_rd] = mem_data_i;
        // pointer write last, so it wins if the target overlaps it
        if (ld_op == OP_INDIRECT_LOAD_POST_INC) begin
          next_regs[ld_ptr_lo] = step_addr[DATA_W-1:0];
          next_regs[hi_of(ld_ptr_lo)] = step_addr[ADDR_W-1:DATA_W];
        end else if (ld_op == OP_INDIRECT_LOAD_PRE_DEC) begin
          next_regs[ld_ptr_lo] = mem_addr[DATA_W-1:0];
          next_regs[hi_of(ld_ptr_lo)] = mem_addr[ADDR_W-1:DATA_W];
        end
        next_state = ST_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      default: begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // flag group: only bit copy, set and clear ever touch it
  always_comb begin
    next_flags = flags;
    if (state == ST_IDLE && issue_i) begin
      case (op_i)
        OP_BIT_TO_TRANSFER_COPY: begin
          next_flags[FLAG_T] = regs[rr_idx_i][bit_sel_i];
        end
        OP_FLAG_SET: begin
          // covers sign and overflow set by flag number
          next_flags[bit_sel_i] = 1'b1;
        end
        OP_FLAG_CLEAR: begin
          next_flags[bit_sel_i] = 1'b0;
        end
        default: begin
          next_flags = flags;
        end
      endcase
    end
  end

  // peek port is registered, so it shows the file as of the edge before the last
  always_comb begin
    next_rf_rd_data = regs[rf_rd_idx_i];
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
      state <= ST_IDLE;
      ld_op <= OP_NOP;
      ld_rd <= '0;
      ld_ptr_lo <= PTR_Z_LO;
      busy <= 1'b0;
      done <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= '0;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      state <= next_state;
      ld_op <= next_ld_op;
      ld_rd <= next_ld_rd;
      ld_ptr_lo <= next_ld_ptr_lo;
      busy <= next_busy;
      done <= next_done;
      mem_rd <= next_mem_rd;
      mem_addr <= next_mem_addr;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rf_rd_data <= REG_RESET;
    end else begin
      rf_rd_data <= next_rf_rd_data;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign mem_rd_o = mem_rd;
  assign mem_addr_o = mem_addr;
  assign status_flags_o = flags;
  assign rf_rd_data_o = rf_rd_data;
endmodule
`default_nettype wire

// ==== sim/flag_exec_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module flag_exec_sva (
  input wire logic clk_sys_i, // core clock
  input wire logic reset_n_i, // async reset
  input wire logic issue_i, // instruction valid
  input wire exec_pkg::op_t op_i, // operation
  input wire logic [2:0] bit_sel_i, // flag number
  input wire logic busy_o, // load busy
  input wire logic done_o, // done pulse
  input wire logic mem_rd_o, // read strobe
  input wire logic [exec_pkg::DATA_W-1:0] status_flags_o // flags
);
  import exec_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  localparam logic [DATA_W-1:0] ONE_HOT = {{(DATA_W-1){1'b0}}, 1'b1};
  localparam logic [DATA_W-1:0] T_BIT = ONE_HOT << FLAG_T;
  wire logic is_ld = op_i inside {OP_INDIRECT_LOAD,
    OP_INDIRECT_LOAD_POST_INC, OP_INDIRECT_LOAD_PRE_DEC,
    OP_OFFSET_INDIRECT_LOAD};
  wire logic [DATA_W-1:0] flag_bit = ONE_HOT << bit_sel_i;
  sequence s_take(logic c);
    issue_i && !busy_o && c;
  endsequence
  // first cycle strobes memory and blocks the port, second reports done
  sequence s_load_steps;
    mem_rd_o && busy_o ##1 done_o && !busy_o && !mem_rd_o;
  endsequence
  a_load_strobe_busy: assert property (
    s_take(is_ld) |=> mem_rd_o && busy_o)
    else $error("load strobe missing");
  a_load_done_two: assert property (
    s_take(is_ld) |-> ##2 done_o && !busy_o)
    else $error("load not done in two");
  a_load_steps: assert property (
    s_take(is_ld) |=> s_load_steps)
    else $error("load steps out of order");
  a_load_flags_kept: assert property (
    s_take(is_ld) |=> $stable(status_flags_o)[*2])
    else $error("load changed flags");
  a_single_done: assert property (
    s_take(!is_ld) |=> done_o && !busy_o && !mem_rd_o)
    else $error("single op not done");
  a_flag_set_only: assert property (
    s_take(op_i == OP_FLAG_SET) |=>
    status_flags_o == ($past(status_flags_o) | $past(flag_bit)))
    else $error("flag set touched other flags");
  a_flag_clear_only: assert property (
    s_take(op_i == OP_FLAG_CLEAR) |=>
    status_flags_o == ($past(status_flags_o) & ~$past(flag_bit)))
    else $error("flag clear touched other flags");
  a_bit_write_flags: assert property (
    s_take(op_i == OP_TRANSFER_TO_BIT_WRITE) |=> $stable(status_flags_o))
    else $error("bit write changed flags");
  a_bit_copy_other: assert property (
    s_take(op_i == OP_BIT_TO_TRANSFER_COPY) |=>
    ((status_flags_o ^ $past(status_flags_o)) & ~T_BIT) == '0)
    else $error("bit copy touched other flags");
  a_strobe_pulse: assert property (
    mem_rd_o |=> !mem_rd_o)
    else $error("strobe too long");
  a_busy_pulse: assert property (
    busy_o |=> !busy_o)
    else $error("busy longer than one cycle");
endmodule
bind flag_bit_and_indirect_load_exec flag_exec_sva chk_i (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .issue_i(issue_i),
  .op_i(op_i),
  .bit_sel_i(bit_sel_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .mem_rd_o(mem_rd_o),
  .status_flags_o(status_flags_o)
);
`default_nettype wire

// ==== sim/flag_bit_and_indirect_load_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module flag_bit_and_indirect_load_exec_bench;
  import exec_pkg::*;
  logic clk_sys_i = 0, reset_n_i = 0, issue_i = 0;
  op_t op_i = OP_NOP;
  logic [4:0] rd_idx_i = 0, rr_idx_i = 0, rf_rd_idx_i = 0;
  logic [2:0] bit_sel_i = 0;
  logic [7:0] imm_i = 0, mem_data_i = 0, mf;
  ptr_sel_t ptr_sel_i = PTR_X;
  logic [5:0] offset_i = 0;
  logic busy_o, done_o, mem_rd_o;
  logic [15:0] mem_addr_o, p, a;
  logic [7:0] status_flags_o, rf_rd_data_o;
  logic [7:0] m [32];
  int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h66672FF1;
  always #2.5 clk_sys_i = ~clk_sys_i;
  flag_bit_and_indirect_load_exec uut (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .issue_i(issue_i),
    .op_i(op_i),
    .rd_idx_i(rd_idx_i),
    .rr_idx_i(rr_idx_i),
    .bit_sel_i(bit_sel_i),
    .imm_i(imm_i),
    .ptr_sel_i(ptr_sel_i),
    .offset_i(offset_i),
    .mem_data_i(mem_data_i),
    .rf_rd_idx_i(rf_rd_idx_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o),
    .status_flags_o(status_flags_o),
    .rf_rd_data_o(rf_rd_data_o)
  );
  function automatic logic [4:0] lo_of(ptr_sel_t s);
    return s == PTR_X ? PTR_X_LO : s == PTR_Y ? PTR_Y_LO : PTR_Z_LO;
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run_one(input logic [31:0] r);
    logic [4:0] lo;
    op_i = op_t'(4'(r[3:0] % 12));
    {offset_i, bit_sel_i, imm_i} = {r[31:26], r[16:14], r[24:17]};
    {rd_idx_i, rr_idx_i} = r[13:4];
    ptr_sel_i = ptr_sel_t'(2'(r[26:25] % 3));
    mem_data_i = 8'($random(seed));
    if (op_i >= OP_INDIRECT_LOAD && rd_idx_i >= 26) rd_idx_i -= 16;
    lo = lo_of(ptr_sel_i);
    p = {m[lo+1], m[lo]};
    a = op_i == OP_INDIRECT_LOAD_PRE_DEC ? 16'(p - 16'h0001) : p;
    if (op_i == OP_OFFSET_INDIRECT_LOAD) a = p + 16'(offset_i);
    case (op_i)
      OP_NOP: begin
      end
      OP_BIT_TO_TRANSFER_COPY: mf[FLAG_T] = m[rr_idx_i][bit_sel_i];
      OP_TRANSFER_TO_BIT_WRITE: m[rd_idx_i][bit_sel_i] = mf[FLAG_T];
      OP_FLAG_SET: mf[bit_sel_i] = 1'b1;
      OP_FLAG_CLEAR: mf[bit_sel_i] = 1'b0;
      OP_REGISTER_MOVE: m[rd_idx_i] = m[rr_idx_i];
      OP_IMMEDIATE_LOAD: m[rd_idx_i] = imm_i;
      OP_REGISTER_PAIR_COPY: begin
        m[{rd_idx_i[4:1], 1'b0}] = m[{rr_idx_i[4:1], 1'b0}];
        m[{rd_idx_i[4:1], 1'b1}] = m[{rr_idx_i[4:1], 1'b1}];
      end
      default: begin
        if (op_i == OP_INDIRECT_LOAD_POST_INC)
          {m[lo+1], m[lo]} = 16'(p + 16'h0001);
        if (op_i == OP_INDIRECT_LOAD_PRE_DEC) {m[lo+1], m[lo]} = a;
        m[rd_idx_i] = mem_data_i;
      end
    endcase
    issue_i = 1;
    @(negedge clk_sys_i);
    if (op_i >= OP_INDIRECT_LOAD) begin
      chk(16'(mem_rd_o), 16'h0001);
      chk(16'(busy_o), 16'h0001);
      chk(mem_addr_o, a);
      // a flag op offered while busy must be ignored
      op_i = OP_FLAG_SET;
      @(negedge clk_sys_i);
    end
    issue_i = 0;
    chk(16'(done_o), 16'h0001);
    chk(16'(busy_o), 16'h0000);
    chk(16'(mem_rd_o), 16'h0000);
    chk(16'(status_flags_o), 16'(mf));
    rf_rd_idx_i = rd_idx_i;
    @(negedge clk_sys_i);
    chk(16'(rf_rd_data_o), 16'(m[rd_idx_i]));
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    foreach (m[i]) m[i] = REG_RESET;
    mf = FLAGS_RESET;
    repeat (12) @(negedge clk_sys_i);
    reset_n_i = 1;
    chk(16'(status_flags_o), 16'(FLAGS_RESET));
    // pointer wrap below zero, above top, and largest offset
    run_one(32'h0000000A);
    run_one(32'h00000009);
    run_one(32'hFC00000B);
    // no-op, then set T and write it into bit 7 of r1
    run_one(32'h0000000C);
    run_one(32'h00018003);
    run_one(32'h0001C202);
    $display("corner test done");
    reset_n_i = 0;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1;
    foreach (m[i]) m[i] = REG_RESET;
    mf = FLAGS_RESET;
    chk(16'(status_flags_o), 16'(FLAGS_RESET));
    $display("reset test done");
    repeat (400) run_one($random(seed));
    $display("random test done");
    wrap_up;
  end
endmodule
`default_nettype wire
